// >>> rtl/ipflb_pkg.sv
// Purpose: Constants for the interrupt pending flags block
// Assumes: 32-bit Avalon-MM register window, byte addresses
// Notes: Offsets are byte addresses on the register bus
package ipflb_pkg;
    localparam logic [7:0] OFS_PENDING = 8'hc8;
    localparam logic [7:0] OFS_ENABLE = 8'hc4;
    localparam logic [7:0] OFS_CONFIG = 8'hcc;
    localparam int BIT_SOFT = 15;
    localparam int BIT_MBERR = 13;
    localparam int BIT_SBERR = 12;
    localparam int BIT_PIN_LO = 4;
    localparam int BIT_TIMER = 3;
    localparam int BIT_PHY = 2;
    localparam int BIT_WAKE = 1;
    localparam int BIT_DMA = 0;
    localparam int BIT_MASTER_IRQ = 19;
    localparam logic [31:0] PENDING_MASK = 32'h0000_b07f;
    localparam logic [31:0] WC_MASK = 32'h0000_b078;
    localparam logic [31:0] ENABLE_MASK = 32'h0000_b07e;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
endpackage : ipflb_pkg

// >>> rtl/ipflb_rise_detect.sv
// Purpose: Rising edge detector on a synchronous level
// Assumes: Input is synchronous to clk_sys
// Notes: One-cycle pulse on each 0 to 1 change
`timescale 1ns/1ps
module ipflb_rise_detect (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic level_in,
    output logic rise_pulse
);
    logic last_r;
    logic last_nxt;
    always_comb begin
        last_nxt = level_in;
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            last_r <= 1'b0;
        end else begin
            last_r <= last_nxt;
        end
    end
    assign rise_pulse = level_in & ~last_r;
endmodule : ipflb_rise_detect

// >>> rtl/ipflb_wc_bit.sv
// Purpose: One sticky flag, set by hardware, cleared by writing one
// Assumes: Set and clear are one-cycle qualified strobes
// Notes: A set arriving with a clear wins
`timescale 1ns/1ps
module ipflb_wc_bit (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic set_in,
    input wire logic clear_in,
    output logic flag
);
    logic flag_r;
    logic flag_nxt;
    always_comb begin
        flag_nxt = flag_r;
        if (clear_in) begin
            flag_nxt = 1'b0;
        end
        if (set_in) begin
            flag_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end
    assign flag = flag_r;
endmodule : ipflb_wc_bit

// >>> rtl/ipflb_top.sv
// Purpose: Interrupt pending flags bank with enable register and irq output
// Assumes: All event inputs synchronous to clk_sys; Avalon-MM slave with waitrequest
// Notes: Mirrored flags follow their sources; sticky flags clear on written ones
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module ipflb_top (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic master_bus_error,
    input wire logic slave_bus_error,
    input wire logic [2:0] pin_event,
    input wire logic timer_wrap,
    input wire logic phy_irq,
    input wire logic [1:0] wake_source_status,
    input wire logic dma_irq,
    output logic irq
);
    logic [31:0] enable_r;
    logic [31:0] enable_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic wait_r;
    logic wait_nxt;
    logic irq_r;
    logic irq_nxt;
    logic phy_r;
    logic phy_nxt;
    logic dma_r;
    logic dma_nxt;
    logic wake_r;
    logic wake_nxt;
    logic soft_rise;
    logic soft_flag;
    logic mberr_flag;
    logic sberr_flag;
    logic timer_flag;
    logic [2:0] pin_flags;
    logic [31:0] pending;
    logic [31:0] bemask;
    logic wr_take;
    logic [31:0] clr_vec;

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    // Access completes in the cycle after request while waitrequest drops
    assign wr_take = avs_write & ~wait_r;
    assign bemask = lane_mask(avs_byteenable);
    assign clr_vec = (wr_take && avs_address == ipflb_pkg::OFS_PENDING) ?
        (avs_writedata & bemask & ipflb_pkg::WC_MASK) : 32'h0000_0000;

    ipflb_rise_detect u_soft_edge (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .level_in(enable_r[ipflb_pkg::BIT_SOFT]),
        .rise_pulse(soft_rise)
    );

    ipflb_wc_bit u_soft (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .set_in(soft_rise),
        .clear_in(clr_vec[ipflb_pkg::BIT_SOFT]),
        .flag(soft_flag)
    );

    // Only reset_n or a written one clears these
    ipflb_wc_bit u_mberr (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .set_in(master_bus_error),
        .clear_in(clr_vec[ipflb_pkg::BIT_MBERR]),
        .flag(mberr_flag)
    );

    ipflb_wc_bit u_sberr (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .set_in(slave_bus_error),
        .clear_in(clr_vec[ipflb_pkg::BIT_SBERR]),
        .flag(sberr_flag)
    );

    ipflb_wc_bit u_timer (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .set_in(timer_wrap),
        .clear_in(clr_vec[ipflb_pkg::BIT_TIMER]),
        .flag(timer_flag)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            ipflb_wc_bit u_pin (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .set_in(pin_event[gi]),
                .clear_in(clr_vec[ipflb_pkg::BIT_PIN_LO + gi]),
                .flag(pin_flags[gi])
            );
        end
    endgenerate

    always_comb begin
        pending = ipflb_pkg::RESET_VALUE;
        pending[ipflb_pkg::BIT_SOFT] = soft_flag;
        pending[ipflb_pkg::BIT_MBERR] = mberr_flag;
        pending[ipflb_pkg::BIT_SBERR] = sberr_flag;
        pending[ipflb_pkg::BIT_PIN_LO +: 3] = pin_flags;
        pending[ipflb_pkg::BIT_TIMER] = timer_flag;
        pending[ipflb_pkg::BIT_PHY] = phy_r;
        pending[ipflb_pkg::BIT_WAKE] = wake_r;
        pending[ipflb_pkg::BIT_DMA] = dma_r;
    end

    // Mirrored flags: writes never touch them
    always_comb begin
        phy_nxt = phy_irq;
        dma_nxt = dma_irq;
        wake_nxt = |wake_source_status;
    end

    always_comb begin
        enable_nxt = enable_r;
        if (wr_take && avs_address == ipflb_pkg::OFS_ENABLE) begin
            enable_nxt = (enable_r & ~bemask) | (avs_writedata & bemask);
            enable_nxt = enable_nxt & ipflb_pkg::ENABLE_MASK;
        end
    end

    // Dma source is enabled at its own controller, so bit 0 always passes
    always_comb begin
        irq_nxt = |(pending & (enable_r | 32'h0000_0001));
    end

    always_comb begin
        wait_nxt = 1'b1;
        rdata_nxt = rdata_r;
        if ((avs_read || avs_write) && wait_r) begin
            wait_nxt = 1'b0;
        end
        if (avs_read && wait_r) begin
            unique case (avs_address)
                ipflb_pkg::OFS_PENDING: rdata_nxt = pending & ipflb_pkg::PENDING_MASK;
                ipflb_pkg::OFS_ENABLE: rdata_nxt = enable_r;
                ipflb_pkg::OFS_CONFIG: begin
                    rdata_nxt = 32'h0000_0000;
                    rdata_nxt[ipflb_pkg::BIT_MASTER_IRQ] = irq_nxt;
                end
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            enable_r <= ipflb_pkg::RESET_VALUE;
            rdata_r <= 32'h0000_0000;
            wait_r <= 1'b1;
            irq_r <= 1'b0;
            phy_r <= 1'b0;
            dma_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
            irq_r <= irq_nxt;
            phy_r <= phy_nxt;
            dma_r <= dma_nxt;
            wake_r <= wake_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign irq = irq_r;

    soft_latch_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(enable_r[ipflb_pkg::BIT_SOFT]) |=> soft_flag)
        else $error("soft flag missed");

    soft_only_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !soft_flag && !soft_rise |=> !soft_flag)
        else $error("soft flag set without enable edge");

    soft_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clr_vec[ipflb_pkg::BIT_SOFT] && !soft_rise |=> !soft_flag)
        else $error("soft flag not cleared");

    soft_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        soft_flag && !clr_vec[ipflb_pkg::BIT_SOFT] |=> soft_flag)
        else $error("soft flag lost");

    mberr_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        master_bus_error |=> mberr_flag)
        else $error("mberr flag missed");

    mberr_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        mberr_flag && !clr_vec[ipflb_pkg::BIT_MBERR] |=> mberr_flag)
        else $error("mberr lost");

    mberr_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clr_vec[ipflb_pkg::BIT_MBERR] && !master_bus_error |=> !mberr_flag)
        else $error("mberr not cleared");

    sberr_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        slave_bus_error |=> sberr_flag)
        else $error("sberr flag missed");

    sberr_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sberr_flag && !clr_vec[ipflb_pkg::BIT_SBERR] |=> sberr_flag)
        else $error("sberr lost");

    sberr_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clr_vec[ipflb_pkg::BIT_SBERR] && !slave_bus_error |=> !sberr_flag)
        else $error("sberr not cleared");

    pin_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pin_event[1] |=> pin_flags[1])
        else $error("pin flag missed");

    pin_all_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reset_n |=> (pin_flags & $past(pin_event)) == $past(pin_event))
        else $error("pin flags missed");

    pin_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clr_vec[ipflb_pkg::BIT_PIN_LO + 2] && !pin_event[2] |=> !pin_flags[2])
        else $error("pin flag not cleared");

    pin_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pin_flags[0] && !clr_vec[ipflb_pkg::BIT_PIN_LO] |=> pin_flags[0])
        else $error("pin flag lost");

    timer_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        timer_wrap |=> timer_flag)
        else $error("timer flag missed");

    timer_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clr_vec[ipflb_pkg::BIT_TIMER] && !timer_wrap |=> !timer_flag)
        else $error("timer flag not cleared");

    timer_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        timer_flag && !clr_vec[ipflb_pkg::BIT_TIMER] |=> timer_flag)
        else $error("timer flag lost");

    // Checked through reset, so no disable here
    bus_reset_a: assert property (@(posedge clk_sys)
        !reset_n |=> pending == 32'h0000_0000 && !irq)
        else $error("flags survive hardware reset");

    phy_follow_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reset_n |=> phy_r == $past(phy_irq))
        else $error("phy flag differs");

    wake_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wake_source_status != 2'h0 |=> pending[ipflb_pkg::BIT_WAKE])
        else $error("wake flag missed");

    wake_follow_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reset_n |=> wake_r == |$past(wake_source_status))
        else $error("wake flag differs");

    dma_follow_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reset_n |=> pending[ipflb_pkg::BIT_DMA] == $past(dma_irq))
        else $error("dma flag differs");

    ro_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clr_vec & 32'h0000_0007) == 32'h0000_0000)
        else $error("write reaches read-only flag");

    irq_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reset_n |=> irq == |($past(pending) & ($past(enable_r) | 32'h0000_0001)))
        else $error("irq gating wrong");

    cfg_irq_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        avs_read && wait_r && avs_address == ipflb_pkg::OFS_CONFIG |=>
        avs_readdata[ipflb_pkg::BIT_MASTER_IRQ] ==
        |($past(pending) & ($past(enable_r) | 32'h0000_0001)))
        else $error("master indication wrong");

    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ((pending & ~ipflb_pkg::PENDING_MASK) |
        (enable_r & ~ipflb_pkg::ENABLE_MASK)) == 32'h0000_0000)
        else $error("reserved bit set");

    pend_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        avs_read && wait_r && avs_address == ipflb_pkg::OFS_PENDING |=>
        (avs_readdata & ~ipflb_pkg::PENDING_MASK) == 32'h0000_0000)
        else $error("reserved bit read back");
endmodule : ipflb_top

// >>> verification/ipflb_top_tb.sv
// Purpose: Self-checking bench for the interrupt pending flags bank
// Assumes: Avalon-MM slave answers within a few cycles
// Notes: Each scenario is a task that drives the block and judges it
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module ipflb_top_tb;
    localparam logic [7:0] PEND = ipflb_pkg::OFS_PENDING;
    localparam logic [7:0] ENA = ipflb_pkg::OFS_ENABLE;
    localparam logic [7:0] CFG = ipflb_pkg::OFS_CONFIG;
    logic clk_sys = 1'h0;
    logic reset_n = 1'h0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic mberr = 1'h0;
    logic sberr = 1'h0;
    logic [2:0] pin_event = 3'h0;
    logic timer_wrap = 1'h0;
    logic phy_irq = 1'h0;
    logic [1:0] wss = 2'h0;
    logic dma_irq = 1'h0;
    logic irq;
    int n_mismatch = 0;
    int comparisons = 0;
    always #4 clk_sys = ~clk_sys;
    ipflb_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .master_bus_error(mberr),
        .slave_bus_error(sberr), .pin_event(pin_event), .timer_wrap(timer_wrap),
        .phy_irq(phy_irq), .wake_source_status(wss), .dma_irq(dma_irq), .irq(irq));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    // Request held until the edge that samples waitrequest low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int i;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'h0) break;
        end
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        if (i == 20) begin
            n_mismatch++;
            $display("[ERR] %0t bus timeout", $time);
            tally_and_finish();
        end
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'h1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'h0, a, 32'h0000_0000, q);
        `CHK(q, e)
    endtask : rd_chk
    task automatic pulse(input int b);
        @(posedge clk_sys);
        case (b)
            13: mberr <= 1'h1;
            12: sberr <= 1'h1;
            3: timer_wrap <= 1'h1;
            default: pin_event[b-4] <= 1'h1;
        endcase
        @(posedge clk_sys);
        {mberr, sberr, timer_wrap, pin_event} <= 6'h00;
    endtask : pulse
    task automatic t_reset();
        rd_chk(PEND, ipflb_pkg::RESET_VALUE);
        rd_chk(ENA, 32'h0000_0000);
        rd_chk(CFG, 32'h0000_0000);
        rd_chk(8'hd0, 32'h0000_0000);
        `CHK(irq, 1'h0)
        $display("test reset done");
    endtask : t_reset
    task automatic t_soft();
        wr(ENA, 32'h0000_8000);
        tick(2);
        rd_chk(PEND, 32'h0000_8000);
        `CHK(irq, 1'h1)
        rd_chk(CFG, 32'h0008_0000);
        wr(PEND, 32'h0000_0000);
        wr(ENA, 32'h0000_8000);
        rd_chk(PEND, 32'h0000_8000);
        wr(PEND, 32'h0000_8000);
        tick(2);
        rd_chk(PEND, 32'h0000_0000);
        wr(ENA, 32'h0000_0000);
        tick(3);
        rd_chk(PEND, 32'h0000_0000);
        `CHK(irq, 1'h0)
        $display("test soft flag done");
    endtask : t_soft
    task automatic t_sticky();
        int srcs[6] = '{13, 12, 6, 5, 4, 3};
        foreach (srcs[k]) begin
            pulse(srcs[k]);
            rd_chk(PEND, 32'h0000_0001 << srcs[k]);
            `CHK(irq, 1'h0)
            wr(PEND, ~(32'h0000_0001 << srcs[k]));
            rd_chk(PEND, 32'h0000_0001 << srcs[k]);
            wr(PEND, 32'h0000_0001 << srcs[k]);
            rd_chk(PEND, 32'h0000_0000);
        end
        pulse(4);
        pulse(5);
        pulse(6);
        wr(PEND, 32'h0000_0020);
        rd_chk(PEND, 32'h0000_0050);
        wr(PEND, 32'h0000_0050);
        pulse(3);
        tick(3);
        rd_chk(CFG, 32'h0000_0000);
        wr(ENA, 32'h0000_0008);
        tick(3);
        `CHK(irq, 1'h1)
        rd_chk(CFG, 32'h0008_0000);
        wr(PEND, 32'h0000_0008);
        tick(3);
        `CHK(irq, 1'h0)
        wr(ENA, 32'h0000_0000);
        $display("test sticky flags done");
    endtask : t_sticky
    task automatic t_mirror();
        @(posedge clk_sys);
        phy_irq <= 1'h1;
        dma_irq <= 1'h1;
        wss <= 2'h1;
        tick(3);
        `CHK(irq, 1'h1)
        wr(PEND, 32'h0000_0007);
        rd_chk(PEND, 32'h0000_0007);
        @(posedge clk_sys);
        phy_irq <= 1'h0;
        dma_irq <= 1'h0;
        wss <= 2'h2;
        tick(3);
        rd_chk(PEND, 32'h0000_0002);
        @(posedge clk_sys);
        wss <= 2'h0;
        tick(3);
        rd_chk(PEND, 32'h0000_0000);
        $display("test mirrored flags done");
    endtask : t_mirror
    task automatic t_reserved();
        avs_byteenable <= 4'h1;
        wr(ENA, 32'hffff_ffff);
        avs_byteenable <= 4'hf;
        rd_chk(ENA, ipflb_pkg::ENABLE_MASK & 32'h0000_00ff);
        wr(ENA, 32'hffff_ffff);
        rd_chk(ENA, ipflb_pkg::ENABLE_MASK);
        wr(CFG, 32'hffff_ffff);
        rd_chk(CFG, 32'h0008_0000);
        wr(8'hd0, 32'hffff_ffff);
        rd_chk(8'hd0, 32'h0000_0000);
        rd_chk(PEND, 32'h0000_8000);
        wr(PEND, 32'hffff_ffff);
        wr(ENA, 32'h0000_0000);
        rd_chk(PEND, 32'h0000_0000);
        $display("test reserved bits done");
    endtask : t_reserved
    task automatic t_hwreset();
        pulse(13);
        pulse(12);
        rd_chk(PEND, 32'h0000_3000);
        @(posedge clk_sys);
        reset_n <= 1'h0;
        tick(2);
        reset_n <= 1'h1;
        rd_chk(PEND, 32'h0000_0000);
        $display("test hardware reset done");
    endtask : t_hwreset
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'h1;
        t_reset();
        t_soft();
        t_sticky();
        t_mirror();
        t_reserved();
        t_hwreset();
        tally_and_finish();
    end
endmodule : ipflb_top_tb
